//--- pkg/lcgs_regs.vh
// Purpose: Register map and field positions of the gate source select block
// Assumes: Avalon-MM word addressing in bytes, 32-bit data
// Notes: Gate 1 uses the low byte, gate 2 the high byte
`ifndef LCGS_REGS_VH
`define LCGS_REGS_VH
`define LCGS_ADDR_W 4
`define LCGS_OFS_SEL_LOW 4'h0
`define LCGS_OFS_POLARITY 4'h4
`define LCGS_OFS_STATUS 4'h8
`define LCGS_SEL_RESET 16'h0000
`define LCGS_POL_RESET 2'h0
`define LCGS_GATE1_LSB 0
`define LCGS_GATE2_LSB 8
`define LCGS_NUM_SRC 4
`endif

//--- src/lcgs_gate.v
// Purpose: One input gate: OR of enabled true and inverted source signals
// Assumes: Enable byte holds per source an inverted bit (even) and a true bit (odd)
// Notes: Purely combinational; the caller registers the result
`timescale 1ns/100ps
module lcgs_gate #(
   parameter NUM_SRC = 4
) (
   input wire [NUM_SRC-1:0] src,
   input wire [2*NUM_SRC-1:0] enables,
   input wire polarity_invert,
   output wire gate_out
);
   wire [2*NUM_SRC-1:0] terms;
   genvar i;
   generate
      for (i = 0; i < NUM_SRC; i = i + 1) begin : g_src
         // Complement supplied per source
         assign terms[2*i] = enables[2*i] & ~src[i];
         assign terms[2*i+1] = enables[2*i+1] & src[i];
      end
   endgenerate
   // With nothing enabled the OR is zero, so polarity alone picks the level
   assign gate_out = (|terms) ^ polarity_invert;
endmodule

//--- src/lcgs_top.v
// Purpose: Gate source select for gates 1 and 2 with Avalon-MM register access
// Assumes: Source inputs synchronous to clock
// Notes: Gate outputs are registered, one cycle after the sources
//
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/100ps
`include "lcgs_regs.vh"
module lcgs_top #(
   parameter NUM_SRC = `LCGS_NUM_SRC
) (
   input wire clock,
   input wire rst_n,
   input wire [`LCGS_ADDR_W-1:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output wire avs_waitrequest,
   output reg [31:0] avs_readdata,
   input wire [NUM_SRC-1:0] src,
   output reg gate1_out,
   output reg gate2_out
);
   ////////////////////////////////////////////////////////////////////////////
   reg rst_meta_r;
   reg rst_sync_r;
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end
   wire rst_int_n = rst_sync_r;
   ////////////////////////////////////////////////////////////////////////////
   // One wait cycle per access gives read data a register stage
   reg ack_r;
   wire req = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_r;
   reg [15:0] sel_r;
   reg [1:0] pol_r;
   wire g1_nxt;
   wire g2_nxt;
   always @(posedge clock or negedge rst_int_n) begin
      if (!rst_int_n) begin
         ack_r <= 1'b0;
         sel_r <= `LCGS_SEL_RESET;
         pol_r <= `LCGS_POL_RESET;
         avs_readdata <= 32'h00000000;
      end else begin
         ack_r <= req & ~ack_r;
         // Write lands at the edge where the master sees waitrequest low
         if (avs_write & ack_r) begin
            if (avs_address == `LCGS_OFS_SEL_LOW) begin
               if (avs_byteenable[0])
                  sel_r[7:0] <= avs_writedata[7:0];
               if (avs_byteenable[1])
                  sel_r[15:8] <= avs_writedata[15:8];
            end else if (avs_address == `LCGS_OFS_POLARITY && avs_byteenable[0]) begin
               pol_r <= avs_writedata[1:0];
            end
         end
         if (avs_read & ~ack_r) begin
            case (avs_address)
               `LCGS_OFS_SEL_LOW: avs_readdata <= {16'h0000, sel_r};
               `LCGS_OFS_POLARITY: avs_readdata <= {30'h00000000, pol_r};
               `LCGS_OFS_STATUS: avs_readdata <= {30'h00000000, gate2_out, gate1_out};
               default: avs_readdata <= 32'h00000000;
            endcase
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   lcgs_gate #(.NUM_SRC(NUM_SRC)) u_gate1 (
      .src(src),
      .enables(sel_r[`LCGS_GATE1_LSB +: 2*NUM_SRC]),
      .polarity_invert(pol_r[0]),
      .gate_out(g1_nxt)
   );
   lcgs_gate #(.NUM_SRC(NUM_SRC)) u_gate2 (
      .src(src),
      .enables(sel_r[`LCGS_GATE2_LSB +: 2*NUM_SRC]),
      .polarity_invert(pol_r[1]),
      .gate_out(g2_nxt)
   );
   always @(posedge clock or negedge rst_int_n) begin
      if (!rst_int_n) begin
         gate1_out <= 1'b0;
         gate2_out <= 1'b0;
      end else begin
         gate1_out <= g1_nxt;
         gate2_out <= g2_nxt;
      end
   end
endmodule

//--- bench/lcgs_properties.sv
// Purpose: Gate output checks
// Assumes: Writes use all byte lanes
// Notes: Shadow copies follow completed writes
`timescale 1ns/100ps
module lcgs_chk(input wire clock, input wire rst_n, input wire [3:0] avs_address,
   input wire avs_write, input wire [31:0] avs_writedata, input wire avs_waitrequest,
   input wire [3:0] src, input wire gate1_out, input wire gate2_out);
reg [15:0] s_r;
reg [1:0] p_r;
wire we = avs_write & !avs_waitrequest;
always @(posedge clock or negedge rst_n) begin
   if (!rst_n) begin
      s_r <= 16'h0000;
      p_r <= 2'h0;
   end else if (we && avs_address == 4'h0) s_r <= avs_writedata[15:0];
   else if (we && avs_address == 4'h4) p_r <= avs_writedata[1:0];
end
function g(input [7:0] e, input [3:0] x, input v);
   g = |({e[7], e[5], e[3], e[1]} & x | {e[6], e[4], e[2], e[0]} & ~x) ^ v;
endfunction
default clocking @(posedge clock); endclocking
default disable iff (!rst_n);
a_g1_value: assert property (gate1_out == g($past(s_r[7:0]), $past(src), $past(p_r[0])))
   else $error("gate1 wrong");
a_g2_value: assert property (gate2_out == g($past(s_r[15:8]), $past(src), $past(p_r[1])))
   else $error("gate2 wrong");
a_g1_idle: assert property ($past(s_r[7:0]) == 0 |-> gate1_out == $past(p_r[0]))
   else $error("gate1 idle");
a_g2_idle: assert property ($past(s_r[15:8]) == 0 |-> gate2_out == $past(p_r[1]))
   else $error("gate2 idle");
a_g1_both: assert property ($past(s_r[7:0]) == 8'hff |-> gate1_out != $past(p_r[0]))
   else $error("gate1 both");
a_g2_both: assert property ($past(s_r[15:8]) == 8'hff |-> gate2_out != $past(p_r[1]))
   else $error("gate2 both");
a_g1_single: assert property ($past(s_r[7:0]) == 8'h02 |-> gate1_out == $past(src[0] ^ p_r[0]))
   else $error("gate1 leak");
a_g2_single: assert property ($past(s_r[15:8]) == 8'h80 |-> gate2_out == $past(src[3] ^ p_r[1]))
   else $error("gate2 leak");
endmodule
bind lcgs_top lcgs_chk i_chk(.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
   .src(src), .gate1_out(gate1_out), .gate2_out(gate2_out));

//--- bench/tb.sv
// Purpose: Register and gate tests
// Assumes: Full byte lanes on every access
// Notes: Expected gate values worked out by hand
`timescale 1ns/100ps
module tb;
reg clock = 0, rst_n = 0, rd = 0, wr = 0;
reg [3:0] adr = 4'h0, src = 4'h0;
reg [31:0] wd = 32'h0;
wire wt, g1, g2;
wire [31:0] rdat;
integer err_count = 0, checks = 0, i;
lcgs_top i_dut(.clock(clock), .rst_n(rst_n), .avs_address(adr), .avs_read(rd),
   .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf), .avs_waitrequest(wt),
   .avs_readdata(rdat), .src(src), .gate1_out(g1), .gate2_out(g2));
initial forever #2 clock = ~clock;
task chk(input [31:0] got, input [31:0] exp); begin
   checks = checks + 1;
   if (got !== exp) begin
      err_count = err_count + 1;
      $display("wrong value %0t got %h exp %h", $time, got, exp);
   end
end endtask
// Settling wait after release lets the gate register catch up
task acc(input w, input [3:0] a, input [31:0] d); begin
   rd <= !w;
   wr <= w;
   adr <= a;
   wd <= d;
   @(posedge clock);
   while (wt) @(posedge clock);
   rd <= 1'b0;
   wr <= 1'b0;
   repeat (2) @(posedge clock);
end endtask
task report_and_stop; begin
   $display("checks %0d mismatches %0d", checks, err_count);
   if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
   else
      $display("== FAILED ==");
   $finish;
end endtask
initial begin
   #100000 err_count = err_count + 1;
   report_and_stop;
end
initial begin
   repeat (3) @(posedge clock);
   rst_n <= 1;
   repeat (3) @(posedge clock);
   acc(0, 4'h0, 0); chk(rdat, 0);
   for (i = 0; i < 32; i = i + 1) begin
      @(posedge clock) src <= i[4] ? 4'h5 : 4'ha;
      acc(1, 4'h0, 32'h1 << i[3:0]);
      chk({g2, g1}, (src[i[2:1]] ^ !i[0]) << i[3]);
   end
   $display("single enables done");
   @(posedge clock) src <= 4'hc;
   acc(1, 4'h0, 32'ha55a); chk({g2, g1}, 2'h2);
   acc(0, 4'h0, 0); chk(rdat, 32'ha55a);
   acc(1, 4'h4, 3); chk({g2, g1}, 2'h1);
   acc(1, 4'h0, 0); chk({g2, g1}, 2'h3);
   acc(1, 4'h0, 32'hffff); chk({g2, g1}, 2'h0);
   acc(0, 4'hc, 0); chk(rdat, 0);
   $display("mixed enables done");
   report_and_stop;
end
endmodule
